// ### aset_ctrl.sv
// Module: task, event and interrupt control of a serial audio interface
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - A start trigger begins continuous transfer that runs until a stop is requested.
// - The start trigger also starts the master clock generator when its enable is set.
// - A stop trigger halts transfer and stops the master clock generator.
// - Every stop trigger sets the halted flag once transfer has stopped.
// - The receive flag is set when the receive start address is copied inside.
// - While running with reception on, the receive event repeats every buffer count of words.
// - The transmit flag is set when the transmit start address is copied inside.
// - While running with transmission on, the transmit event repeats every buffer count of words.
// - The enable mask holds one read-write bit per event, one meaning enabled.
// - Writing ones to the enable-set register sets enables; reads show the enables.
// - Writing ones to the enable-clear register clears enables; reads show the enables.
// - One buffer word count gives the length and event period of both directions.
// - With the clock enable set (its reset state) the generator drives the pin, else releases it.
module aset_ctrl (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    // Wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [11:0] i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    // Serial link, from outside the clock domain
    input  wire logic        i_link_bit_clk,
    input  wire logic        i_link_word_sel,
    // Unit control
    output logic             o_rx_active,
    output logic             o_tx_active,
    output logic      [31:0] o_rx_buf_cur,
    output logic      [31:0] o_tx_buf_cur,
    // Master clock pin
    output logic             o_master_audio_clock,
    output logic             o_master_audio_clock_oe,
    // Interrupt
    output logic             o_irq
);

    // ****************************************
    // Register state
    // ****************************************
    aset_pkg::aset_state_type state_r;
    aset_pkg::aset_state_type state_nxt;
    logic                       rx_flag_r;
    logic                       halt_flag_r;
    logic                       tx_flag_r;
    logic [31:0]                mask_r;
    logic                       rx_en_r;
    logic                       tx_en_r;
    logic                       mck_en_r;
    logic [31:0]                rx_start_r;
    logic [31:0]                tx_start_r;
    logic [aset_pkg::CNT_W-1:0] word_cnt_r;
    logic [31:0]                rx_cur_r;
    logic [31:0]                tx_cur_r;
    logic                       ack_r;
    logic [31:0]                rdat_r;
    logic [7:0]                 mck_div_r;
    logic                       mck_r;

    // ****************************************
    // Bus decode
    // ****************************************
    wire        req      = i_wb_cyc & i_wb_stb & ~ack_r;
    wire        wr       = req & i_wb_we;
    wire [31:0] lane     = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                            {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    wire        wr_lo    = wr & i_wb_sel[0];
    wire        hit_start = i_wb_adr == aset_pkg::OFS_START_TRIG;
    wire        hit_stop  = i_wb_adr == aset_pkg::OFS_STOP_TRIG;
    wire        hit_rxf   = i_wb_adr == aset_pkg::OFS_RX_FLAG;
    wire        hit_hlf   = i_wb_adr == aset_pkg::OFS_HALT_FLAG;
    wire        hit_txf   = i_wb_adr == aset_pkg::OFS_TX_FLAG;
    wire        hit_mask  = i_wb_adr == aset_pkg::OFS_IRQ_MASK;
    wire        hit_set   = i_wb_adr == aset_pkg::OFS_IRQ_SET;
    wire        hit_clr   = i_wb_adr == aset_pkg::OFS_IRQ_CLR;
    wire        hit_reception_enable  = i_wb_adr == aset_pkg::OFS_RX_EN;
    wire        hit_transmission_enable  = i_wb_adr == aset_pkg::OFS_TX_EN;
    wire        hit_master_clock_gen_enable = i_wb_adr == aset_pkg::OFS_MCK_EN;
    wire        hit_rxs   = i_wb_adr == aset_pkg::OFS_RX_START;
    wire        hit_txs   = i_wb_adr == aset_pkg::OFS_TX_START;
    wire        hit_cnt   = i_wb_adr == aset_pkg::OFS_WORD_CNT;

    // ****************************************
    // Tasks
    // ****************************************
    wire start_trig = wr_lo & hit_start & i_wb_dat[0];
    wire stop_trig  = wr_lo & hit_stop & i_wb_dat[0];

    // Stop has priority when both land together in idle or run: the halted flag must follow
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            aset_pkg::ST_IDLE: begin
                if (stop_trig) begin
                    state_nxt = aset_pkg::ST_HALT;
                end else if (start_trig) begin
                    state_nxt = aset_pkg::ST_RUN;
                end
            end
            aset_pkg::ST_RUN: begin
                if (stop_trig) begin
                    state_nxt = aset_pkg::ST_HALT;
                end
            end
            aset_pkg::ST_HALT: begin
                state_nxt = start_trig ? aset_pkg::ST_RUN : aset_pkg::ST_IDLE;
            end
            default: state_nxt = aset_pkg::ST_IDLE;
        endcase
    end

    wire running  = state_r == aset_pkg::ST_RUN;
    wire halt_evt = state_r == aset_pkg::ST_HALT;
    wire go_run   = state_r != aset_pkg::ST_RUN && state_nxt == aset_pkg::ST_RUN;

    // ****************************************
    // Link sampling, two flops before use
    // ****************************************
    logic [1:0] bclk_sync_r;
    logic [1:0] wsel_sync_r;
    logic       bclk_prev_r;
    logic       wsel_prev_r;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            bclk_sync_r <= 2'h0;
            wsel_sync_r <= 2'h0;
            bclk_prev_r <= 1'b0;
            wsel_prev_r <= 1'b0;
        end else begin
            bclk_sync_r <= {bclk_sync_r[0], i_link_bit_clk};
            wsel_sync_r <= {wsel_sync_r[0], i_link_word_sel};
            bclk_prev_r <= bclk_sync_r[1];
            if (bclk_sync_r[1] & ~bclk_prev_r) begin
                wsel_prev_r <= wsel_sync_r[1];
            end
        end
    end

    // One word ends at each word-select change seen on a bit clock rise
    wire bclk_rise = bclk_sync_r[1] & ~bclk_prev_r;
    wire word_done = bclk_rise & (wsel_sync_r[1] != wsel_prev_r);

    // ****************************************
    // Event flags, set wins over a clearing write
    // ****************************************
    wire rx_clr   = wr_lo & hit_rxf & ~i_wb_dat[0];
    wire halt_clr = wr_lo & hit_hlf & ~i_wb_dat[0];
    wire tx_clr   = wr_lo & hit_txf & ~i_wb_dat[0];
    wire rx_on    = running & rx_en_r;
    wire tx_on    = running & tx_en_r;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            halt_flag_r <= 1'b0;
        end else begin
            halt_flag_r <= halt_evt | (halt_flag_r & ~halt_clr);
        end
    end

    // ****************************************
    // Word counters and double-buffer copies
    // ****************************************
    // Both directions share one word count, so their events line up
    aset_dir_track u_rx_track (
        .i_ref_clk    (i_ref_clk),
        .i_rst        (i_rst),
        .i_go         (go_run),
        .i_en         (rx_en_r),
        .i_on         (rx_on),
        .i_word       (word_done),
        .i_word_cnt   (word_cnt_r),
        .i_start_addr (rx_start_r),
        .i_clear      (rx_clr),
        .o_cur_addr   (rx_cur_r),
        .o_flag       (rx_flag_r)
    );

    aset_dir_track u_tx_track (
        .i_ref_clk    (i_ref_clk),
        .i_rst        (i_rst),
        .i_go         (go_run),
        .i_en         (tx_en_r),
        .i_on         (tx_on),
        .i_word       (word_done),
        .i_word_cnt   (word_cnt_r),
        .i_start_addr (tx_start_r),
        .i_clear      (tx_clr),
        .o_cur_addr   (tx_cur_r),
        .o_flag       (tx_flag_r)
    );

    // ****************************************
    // Interrupt enables and configuration
    // ****************************************
    wire [31:0] irq_bits = (32'h1 << aset_pkg::BIT_RX)
                         | (32'h1 << aset_pkg::BIT_HALT)
                         | (32'h1 << aset_pkg::BIT_TX);
    wire [31:0] wmask    = i_wb_dat & lane & irq_bits;
    wire [31:0] mask_wr  = (mask_r & ~(lane & irq_bits)) | wmask;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            mask_r     <= aset_pkg::RST_ZERO;
            rx_en_r    <= 1'b0;
            tx_en_r    <= 1'b0;
            mck_en_r   <= aset_pkg::RST_MCK_EN;
            rx_start_r <= aset_pkg::RST_ZERO;
            tx_start_r <= aset_pkg::RST_ZERO;
            word_cnt_r <= '0;
        end else begin
            if (wr & hit_mask) begin
                mask_r <= mask_wr;
            end else if (wr & hit_set) begin
                mask_r <= mask_r | wmask;
            end else if (wr & hit_clr) begin
                mask_r <= mask_r & ~wmask;
            end
            if (wr_lo & hit_reception_enable) begin
                rx_en_r <= i_wb_dat[0];
            end
            if (wr_lo & hit_transmission_enable) begin
                tx_en_r <= i_wb_dat[0];
            end
            if (wr_lo & hit_master_clock_gen_enable) begin
                mck_en_r <= i_wb_dat[0];
            end
            if (wr & hit_rxs) begin
                rx_start_r <= (rx_start_r & ~lane) | (i_wb_dat & lane);
            end
            if (wr & hit_txs) begin
                tx_start_r <= (tx_start_r & ~lane) | (i_wb_dat & lane);
            end
            if (wr & hit_cnt) begin
                word_cnt_r <= (word_cnt_r & ~lane[aset_pkg::CNT_W-1:0])
                            | (i_wb_dat[aset_pkg::CNT_W-1:0] & lane[aset_pkg::CNT_W-1:0]);
            end
        end
    end

    // ****************************************
    // Master clock generator
    // ****************************************
    // Runs only while transferring; stop freezes it low
    wire mck_run  = running & mck_en_r;
    wire mck_tick = mck_div_r == aset_pkg::MCK_HALF - 8'h1;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            mck_div_r <= 8'h0;
            mck_r     <= 1'b0;
        end else if (!mck_run) begin
            mck_div_r <= 8'h0;
            mck_r     <= 1'b0;
        end else if (mck_tick) begin
            mck_div_r <= 8'h0;
            mck_r     <= ~mck_r;
        end else begin
            mck_div_r <= mck_div_r + 8'h1;
        end
    end

    // ****************************************
    // Read mux and acknowledge
    // ****************************************
    wire [31:0] flag_rd  = {31'h0, hit_rxf ? rx_flag_r : hit_hlf ? halt_flag_r : tx_flag_r};
    wire        flag_hit = hit_rxf | hit_hlf | hit_txf;
    wire        mask_hit = hit_mask | hit_set | hit_clr;
    wire [31:0] rd_mux   = flag_hit  ? flag_rd
                         : mask_hit  ? mask_r
                         : hit_reception_enable  ? {31'h0, rx_en_r}
                         : hit_transmission_enable  ? {31'h0, tx_en_r}
                         : hit_master_clock_gen_enable ? {31'h0, mck_en_r}
                         : hit_rxs   ? rx_start_r
                         : hit_txs   ? tx_start_r
                         : hit_cnt   ? {{(32-aset_pkg::CNT_W){1'b0}}, word_cnt_r}
                         : aset_pkg::RST_ZERO;

    // One wait-free cycle: ack follows the request by one edge
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_r <= aset_pkg::ST_IDLE;
            ack_r   <= 1'b0;
            rdat_r  <= aset_pkg::RST_ZERO;
        end else begin
            state_r <= state_nxt;
            ack_r   <= req;
            if (req & ~i_wb_we) begin
                rdat_r <= rd_mux;
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_wb_ack                = ack_r;
    assign o_wb_dat                = rdat_r;
    assign o_rx_active             = running & rx_en_r;
    assign o_tx_active             = running & tx_en_r;
    assign o_rx_buf_cur            = rx_cur_r;
    assign o_tx_buf_cur            = tx_cur_r;
    assign o_master_audio_clock    = mck_r;
    assign o_master_audio_clock_oe = mck_en_r;
    assign o_irq = |({26'h0, tx_flag_r, 2'h0, halt_flag_r, rx_flag_r, 1'b0} & mask_r);

endmodule

// ****************************************
// Per-direction tracker: word count, pointer copy and event flag
// ****************************************
module aset_dir_track (
    // Clock and reset
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_rst,
    // Control
    input  wire logic                       i_go,
    input  wire logic                       i_en,
    input  wire logic                       i_on,
    input  wire logic                       i_word,
    input  wire logic [aset_pkg::CNT_W-1:0] i_word_cnt,
    input  wire logic [31:0]                i_start_addr,
    input  wire logic                       i_clear,
    // Status
    output logic      [31:0]                o_cur_addr,
    output logic                            o_flag
);

    // ****************************************
    // Counter, pointer copy and flag
    // ****************************************
    logic [aset_pkg::CNT_W-1:0] cnt_r;
    logic [31:0]                cur_r;
    logic                       flag_r;

    // A zero count never completes a buffer, so no periodic event fires
    wire [aset_pkg::CNT_W-1:0] last = i_word_cnt - aset_pkg::CNT_W'(1);
    wire step = i_on & i_word;
    wire wrap = step & (i_word_cnt != '0) & (cnt_r == last);
    wire copy = (i_go & i_en) | wrap;

    // Counter restarts at every start so each run begins a fresh buffer
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cnt_r  <= '0;
            cur_r  <= aset_pkg::RST_ZERO;
            flag_r <= 1'b0;
        end else begin
            if (i_go | wrap) begin
                cnt_r <= '0;
            end else if (step) begin
                cnt_r <= cnt_r + aset_pkg::CNT_W'(1);
            end
            if (copy) begin
                cur_r <= i_start_addr;
            end
            flag_r <= copy | (flag_r & ~i_clear);
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_cur_addr = cur_r;
    assign o_flag     = flag_r;

endmodule
`default_nettype wire

// ### aset_pkg.sv
// Package: register map, field layout, reset values and timing of the audio task/event block
package aset_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [11:0] OFS_START_TRIG = 12'h000;
    localparam logic [11:0] OFS_STOP_TRIG  = 12'h004;
    localparam logic [11:0] OFS_RX_FLAG    = 12'h104;
    localparam logic [11:0] OFS_HALT_FLAG  = 12'h108;
    localparam logic [11:0] OFS_TX_FLAG    = 12'h114;
    localparam logic [11:0] OFS_IRQ_MASK   = 12'h300;
    localparam logic [11:0] OFS_IRQ_SET    = 12'h304;
    localparam logic [11:0] OFS_IRQ_CLR    = 12'h308;
    localparam logic [11:0] OFS_RX_EN      = 12'h508;
    localparam logic [11:0] OFS_TX_EN      = 12'h50c;
    localparam logic [11:0] OFS_MCK_EN     = 12'h510;
    localparam logic [11:0] OFS_RX_START   = 12'h538;
    localparam logic [11:0] OFS_TX_START   = 12'h540;
    localparam logic [11:0] OFS_WORD_CNT   = 12'h550;

    // ****************************************
    // Interrupt enable bit positions
    // ****************************************
    localparam int BIT_RX   = 1;
    localparam int BIT_HALT = 2;
    localparam int BIT_TX   = 5;

    // ****************************************
    // Widths and reset values
    // ****************************************
    localparam int          CNT_W       = 14;
    localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
    localparam logic        RST_MCK_EN  = 1'b1;

    // ****************************************
    // Timing: master clock of 4 MHz from 200 MHz
    // ****************************************
    localparam int          CLK_MHZ     = 200;
    localparam int          MCK_MHZ     = 4;
    localparam logic [7:0]  MCK_HALF    = 8'((CLK_MHZ / MCK_MHZ) / 2);

    // ****************************************
    // Transfer states
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_HALT = 3'b100
    } aset_state_type;

endpackage

// ### aset_ctrl_properties.sv
// Checker: bus, interrupt and master clock properties of the audio task/event block
`timescale 1ns/1ps
`default_nettype none
module aset_ctrl_checker (
    // Clock and reset
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    // Bus
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [11:0] i_wb_adr,
    input wire logic [3:0]  i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    // Unit outputs
    input wire logic        o_rx_active,
    input wire logic        o_tx_active,
    input wire logic        o_master_audio_clock,
    input wire logic        o_master_audio_clock_oe,
    input wire logic        o_irq
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    wire        take_w = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wire        wr_w   = take_w && i_wb_we && i_wb_sel[0];
    logic [7:0] mck_hi_r;
    // Length of the current high phase of the master clock
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || !o_master_audio_clock) begin
            mck_hi_r <= 8'h00;
        end else begin
            mck_hi_r <= mck_hi_r + 8'h01;
        end
    end
    a_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");
    a_ack_follows_req: assert property (take_w |=> o_wb_ack)
        else $error("request not acknowledged");
    a_ack_has_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
        else $error("ack without request");
    a_unmapped_reads_zero: assert property (
        take_w && !i_wb_we && i_wb_adr[11:10] == 2'b11 |=> o_wb_dat == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_irq_all_masked: assert property (
        wr_w && i_wb_adr == aset_pkg::OFS_IRQ_CLR && i_wb_dat[1] && i_wb_dat[2] && i_wb_dat[5]
        |-> ##2 !o_irq)
        else $error("irq with all enables cleared");
    a_stop_halts_all: assert property (
        wr_w && i_wb_adr == aset_pkg::OFS_STOP_TRIG && i_wb_dat[0]
        |-> ##3 !(o_rx_active || o_tx_active || o_master_audio_clock))
        else $error("transfer or clock still running after stop");
    a_mck_needs_enable: assert property (
        !o_master_audio_clock_oe [*2] |-> !o_master_audio_clock)
        else $error("master clock driven while released");
    a_mck_half_period: assert property (mck_hi_r <= aset_pkg::MCK_HALF)
        else $error("master clock high phase too long");
endmodule
bind aset_ctrl aset_ctrl_checker u_aset_ctrl_checker (.i_ref_clk, .i_rst, .i_wb_cyc, .i_wb_stb,
    .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_rx_active, .o_tx_active,
    .o_master_audio_clock, .o_master_audio_clock_oe, .o_irq);
`default_nettype wire

// ### aset_codec_model.sv
// Model: external codec making the link bit clock and word select
`timescale 1ns/1ps
`default_nettype none
module aset_codec_model #(
    parameter int BITS = 4
) (
    // Control
    input  wire logic i_en,
    // Link
    output logic      o_link_bit_clk,
    output logic      o_link_word_sel
);
    // Clock finishes the current word, then stands still while disabled; word select moves only on falling edges
    initial begin
        o_link_bit_clk = 1'b0;
        o_link_word_sel = 1'b0;
        forever begin
            wait (i_en);
            repeat (BITS) begin
                #62.5 o_link_bit_clk = 1'b1;
                #62.5 o_link_bit_clk = 1'b0;
            end
            o_link_word_sel = ~o_link_word_sel;
        end
    end
endmodule
`default_nettype wire

// ### aset_ctrl_bench.sv
// Testbench: self-checking bench of the audio task/event block
`timescale 1ns/1ps
`default_nettype none
module aset_ctrl_bench;
    logic        i_ref_clk, i_rst, i_wb_cyc, i_wb_stb, i_wb_we, codec_en;
    logic [11:0] i_wb_adr;
    logic [3:0]  i_wb_sel;
    logic [31:0] i_wb_dat, o_wb_dat, o_rx_buf_cur, o_tx_buf_cur;
    logic        o_wb_ack, o_rx_active, o_tx_active, o_irq;
    logic        o_master_audio_clock, o_master_audio_clock_oe;
    wire         i_link_bit_clk, i_link_word_sel;
    int          failures, total_checks, cycles;
    aset_ctrl u_aset_ctrl (.i_ref_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
        .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_link_bit_clk, .i_link_word_sel,
        .o_rx_active, .o_tx_active, .o_rx_buf_cur, .o_tx_buf_cur, .o_master_audio_clock,
        .o_master_audio_clock_oe, .o_irq);
    aset_codec_model u_aset_codec_model (.i_en(codec_en), .o_link_bit_clk(i_link_bit_clk),
        .o_link_word_sel(i_link_word_sel));
    // ********
    // Clock, timeout and checking
    // ********
    initial begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            $display("BAD t=%0t timeout", $time);
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Classic cycle: hold everything until ack is sampled, then release
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge i_ref_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= w;
        i_wb_adr <= a;
        i_wb_dat <= d;
        @(posedge i_ref_clk);
        while (o_wb_ack !== 1'b1) @(posedge i_ref_clk);
        q = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, e);
    endtask
    function automatic logic [31:0] ev_bits();
        return (32'h1 << aset_pkg::BIT_RX) | (32'h1 << aset_pkg::BIT_HALT)
            | (32'h1 << aset_pkg::BIT_TX);
    endfunction
    // ********
    // Main sequence
    // ********
    initial begin
        logic [31:0] m, r, ra, ta;
        int          t0;
        {i_rst, i_wb_cyc, i_wb_stb, i_wb_we, codec_en} = 5'b10000;
        {i_wb_adr, i_wb_dat, m, failures, total_checks, cycles} = '0;
        i_wb_sel = 4'hf;
        void'($urandom(98431));
        repeat (10) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        rd_chk(aset_pkg::OFS_IRQ_MASK, 32'h0);
        rd_chk(aset_pkg::OFS_MCK_EN, 32'h1);
        check(o_master_audio_clock_oe, 1'b1);
        check(o_irq, 1'b0);
        for (int i = 0; i < 4; i++) begin
            r = $urandom;
            wr(aset_pkg::OFS_IRQ_SET, r);
            m = m | (r & ev_bits());
            rd_chk(aset_pkg::OFS_IRQ_SET, m);
            r = $urandom;
            wr(aset_pkg::OFS_IRQ_CLR, r);
            m = m & ~(r & ev_bits());
            rd_chk(aset_pkg::OFS_IRQ_CLR, m);
        end
        wr(aset_pkg::OFS_IRQ_MASK, ev_bits());
        wr(aset_pkg::OFS_IRQ_SET, 32'h0);
        rd_chk(aset_pkg::OFS_IRQ_MASK, ev_bits());
        rd_chk(12'hffc, 32'h0);
        $display("test registers done");
        ra = $urandom;
        ta = $urandom;
        wr(aset_pkg::OFS_RX_EN, 32'h1);
        wr(aset_pkg::OFS_TX_EN, 32'h1);
        wr(aset_pkg::OFS_RX_START, ra);
        wr(aset_pkg::OFS_TX_START, ta);
        wr(aset_pkg::OFS_WORD_CNT, 32'h4);
        wr(aset_pkg::OFS_START_TRIG, 32'h1);
        codec_en <= 1'b1;
        t0 = cycles;
        @(negedge i_ref_clk);
        check({o_rx_active, o_tx_active, o_irq}, 3'b111);
        check(o_rx_buf_cur, ra);
        check(o_tx_buf_cur, ta);
        rd_chk(aset_pkg::OFS_RX_FLAG, 32'h1);
        rd_chk(aset_pkg::OFS_TX_FLAG, 32'h1);
        wr(aset_pkg::OFS_RX_START, ~ra);
        wr(aset_pkg::OFS_TX_START, ~ta);
        wr(aset_pkg::OFS_RX_FLAG, 32'h0);
        wr(aset_pkg::OFS_TX_FLAG, 32'h0);
        @(negedge i_ref_clk);
        check(o_irq, 1'b0);
        while (o_irq !== 1'b1) @(posedge i_ref_clk);
        check(cycles - t0 >= 350 && cycles - t0 <= 500, 1'b1);
        repeat (4) @(posedge i_ref_clk);
        rd_chk(aset_pkg::OFS_RX_FLAG, 32'h1);
        rd_chk(aset_pkg::OFS_TX_FLAG, 32'h1);
        check({o_rx_buf_cur, o_tx_buf_cur}, {~ra, ~ta});
        while (o_master_audio_clock !== 1'b0) @(posedge i_ref_clk);
        while (o_master_audio_clock !== 1'b1) @(posedge i_ref_clk);
        t0 = cycles;
        while (o_master_audio_clock !== 1'b0) @(posedge i_ref_clk);
        while (o_master_audio_clock !== 1'b1) @(posedge i_ref_clk);
        check(32'(cycles - t0), 32'(aset_pkg::MCK_HALF) * 2);
        $display("test stream done");
        wr(aset_pkg::OFS_STOP_TRIG, 32'h1);
        codec_en <= 1'b0;
        repeat (4) @(negedge i_ref_clk);
        check({o_rx_active, o_tx_active, o_master_audio_clock}, 3'b000);
        rd_chk(aset_pkg::OFS_HALT_FLAG, 32'h1);
        wr(aset_pkg::OFS_IRQ_CLR, 32'hffff_ffff);
        check(o_irq, 1'b0);
        wr(aset_pkg::OFS_IRQ_SET, 32'h1 << aset_pkg::BIT_HALT);
        check(o_irq, 1'b1);
        wr(aset_pkg::OFS_HALT_FLAG, 32'h0);
        @(negedge i_ref_clk);
        check(o_irq, 1'b0);
        $display("test stop done");
        wr(aset_pkg::OFS_MCK_EN, 32'h0);
        wr(aset_pkg::OFS_RX_EN, 32'h0);
        check(o_master_audio_clock_oe, 1'b0);
        wr(aset_pkg::OFS_START_TRIG, 32'h1);
        codec_en <= 1'b1;
        repeat (80) @(negedge i_ref_clk);
        check({o_master_audio_clock, o_rx_active, o_tx_active}, 3'b001);
        wr(aset_pkg::OFS_STOP_TRIG, 32'h1);
        codec_en <= 1'b0;
        wr(aset_pkg::OFS_HALT_FLAG, 32'h0);
        wr(aset_pkg::OFS_STOP_TRIG, 32'h1);
        rd_chk(aset_pkg::OFS_HALT_FLAG, 32'h1);
        $display("test clock disabled done");
        finish_test();
    end
endmodule
`default_nettype wire
